/* verilog/tcc_pkg.sv */
// shared constants and types of the temperature conversion control block
package tcc_pkg;

  ////////////////////////////////////////
  // widths and sizes
  localparam int TCC_TEMP_W     = 16;
  localparam int TCC_FIFO_DEPTH = 32;
  localparam int TCC_ROM_W      = 64;
  localparam int TCC_NUM_GPIO   = 3;
  localparam int TCC_CMD_W      = 8;

  // one count of the signed result is 0.005 degC, held in micro-degC
  localparam int TCC_STEP_UDEGC = 5000;

  ////////////////////////////////////////
  // function command that starts a conversion
  localparam logic [TCC_CMD_W-1:0] TCC_CMD_CONVERT = 8'h44;

  ////////////////////////////////////////
  // general pin mode field encoding, two bits per pin
  typedef logic [1:0] tcc_mode_type;
  localparam tcc_mode_type TCC_MODE_HIZ     = 2'h0;
  localparam tcc_mode_type TCC_MODE_OD_OUT  = 2'h1;
  localparam tcc_mode_type TCC_MODE_PULLDN  = 2'h2;
  localparam tcc_mode_type TCC_MODE_SPECIAL = 2'h3;

  // pin positions of the special functions
  localparam int TCC_PIN_INT  = 0;
  localparam int TCC_PIN_CONV = 1;

  // interrupt enable field positions
  localparam int TCC_INT_EN_HI_POS = 0;
  localparam int TCC_INT_EN_LO_POS = 1;

  ////////////////////////////////////////
  // reset values
  localparam logic [2*TCC_NUM_GPIO-1:0] TCC_GPIO_MODE_RST = 6'h2a;
  localparam logic [TCC_NUM_GPIO-1:0]   TCC_GPIO_OUT_RST  = 3'h7;
  localparam logic [TCC_TEMP_W-1:0]     TCC_ALARM_HI_RST  = 16'h7fff;
  localparam logic [TCC_TEMP_W-1:0]     TCC_ALARM_LO_RST  = 16'h8000;
  localparam logic [1:0]                TCC_INT_EN_RST    = 2'h0;

  // serial code default; the value is arbitrary
  localparam logic [TCC_ROM_W-1:0] TCC_ROM_CODE_DFLT = 64'h0123_4567_89ab_cdef;

  ////////////////////////////////////////
  // conversion sequencer states
  typedef enum logic [1:0] {
    TCC_ST_STANDBY,
    TCC_ST_START,
    TCC_ST_WAIT,
    TCC_ST_STORE
  } tcc_state_type;

endpackage : tcc_pkg

/* verilog/tcc_res_if.sv */
// result path between the conversion sequencer and the result store
`timescale 1ns/100ps
`default_nettype none

interface tcc_res_if #(
  parameter int W     = 16,
  parameter int DEPTH = 32
);
  logic                   push;
  logic [W-1:0]           push_data;
  logic                   pop;
  logic [W-1:0]           head;
  logic                   full;
  logic                   empty;
  logic [$clog2(DEPTH):0] count;

  modport ctrl (
    output push,
    output push_data,
    output pop,
    input  head,
    input  full,
    input  empty,
    input  count
  );

  modport store (
    input  push,
    input  push_data,
    input  pop,
    output head,
    output full,
    output empty,
    output count
  );
endinterface : tcc_res_if

`default_nettype wire

/* verilog/tcc_fifo.sv */
// result store: flip-flop fifo of temperature words
`timescale 1ns/100ps
`default_nettype none

module tcc_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic     clk_i,
  input  wire logic     srst_i,
  // fifo port
  tcc_res_if.store      res
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0]   count_r;

  wire do_push = res.push & ~res.full;
  wire do_pop  = res.pop & ~res.empty;

  assign res.head  = mem_r[rd_ptr_r];
  assign res.full  = (count_r == (AW+1)'(DEPTH));
  assign res.empty = (count_r == '0);
  assign res.count = count_r;

  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem_r[wr_ptr_r] <= res.push_data;
    end
  end

  // pointers wrap freely since depth is a power of two
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_r + AW'(do_push);
      rd_ptr_r <= rd_ptr_r + AW'(do_pop);
      count_r  <= count_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

endmodule : tcc_fifo

`default_nettype wire

/* verilog/tcc_pin_sync.sv */
// three-stage synchroniser with agreement filter for external pins
`timescale 1ns/100ps
`default_nettype none

module tcc_pin_sync #(
  parameter int N = 3
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  // pins and filtered levels
  input  wire logic [N-1:0] pin_i,
  output logic      [N-1:0] level_o
);

  logic [N-1:0] s1_r;
  logic [N-1:0] s2_r;
  logic [N-1:0] s3_r;
  logic [N-1:0] level_r;

  assign level_o = level_r;

  // s1 feeds only s2; the level moves once s2 and s3 agree
  for (genvar i = 0; i < N; i++) begin : g_bit
    wire agree = (s2_r[i] == s3_r[i]);
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        s1_r[i]    <= 1'b0;
        s2_r[i]    <= 1'b0;
        s3_r[i]    <= 1'b0;
        level_r[i] <= 1'b0;
      end else begin
        s1_r[i] <= pin_i[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
        if (agree) begin
          level_r[i] <= s3_r[i];
        end
      end
    end
  end

endmodule : tcc_pin_sync

`default_nettype wire

/* verilog/tcc_top.sv */
// conversion control, result fifo, alarms and general pins of the sensor
//
// Functional notes
// R1: after reset the block sits in low-power standby until a conversion request.
// R2: function command 0x44 from the bus master starts one conversion.
// R3: pin one in special mode starts a conversion on its rising edge.
// R4: master keeps bus idle with strong pullup during the whole conversion.
// R5: finished conversion pushes one two-byte word into the fifo, then standby.
// R6: result fifo holds up to thirty-two results.
// R7: result is sixteen-bit two's complement, msb set for negative temperatures.
// R8: each signed count stands for 0.005 degC.
// R9: a unique 64-bit serial code sits in read-only storage.
// R10: two-byte upper and lower alarm thresholds, volatile.
// R11: pin zero in special mode is an open-drain active-low interrupt output.
// R12: pins in input modes give their levels as three location bits.
// R13: data line is open-drain only; device pulls low or releases.
// R14: two-bit mode per pin: hiz, open-drain out, pulldown (default), special.
// R15: after each conversion compare result with both thresholds, signed.
// R16: requests during a running conversion are ignored without harm.
`timescale 1ns/100ps
`default_nettype none

module tcc_top
  import tcc_pkg::*;
#(
  parameter logic [tcc_pkg::TCC_ROM_W-1:0] ROM_CODE   = tcc_pkg::TCC_ROM_CODE_DFLT,
  parameter int                            FIFO_DEPTH = tcc_pkg::TCC_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                               CLK_SYS_I,
  input  wire logic                               SRST_I,
  // decoded function commands from the bus link layer
  input  wire logic                               CMD_VALID_I,
  input  wire logic [tcc_pkg::TCC_CMD_W-1:0]      CMD_CODE_I,
  // data line, open-drain
  input  wire logic                               DQ_PULL_LOW_I,
  output logic                                    DQ_O,
  output logic                                    DQ_OE_N_O,
  // converter handshake
  output logic                                    ADC_START_O,
  input  wire logic                               ADC_DONE_I,
  input  wire logic [tcc_pkg::TCC_TEMP_W-1:0]     ADC_DATA_I,
  // conversion status
  output logic                                    STANDBY_O,
  output logic                                    CONV_BUSY_O,
  output logic [tcc_pkg::TCC_TEMP_W-1:0]          LAST_RESULT_O,
  // result fifo read side
  input  wire logic                               FIFO_POP_I,
  output logic [tcc_pkg::TCC_TEMP_W-1:0]          FIFO_DATA_O,
  output logic [$clog2(FIFO_DEPTH):0]             FIFO_COUNT_O,
  output logic                                    FIFO_EMPTY_O,
  output logic                                    FIFO_OVF_O,
  // alarm thresholds and enables
  input  wire logic                               THR_HI_WR_I,
  input  wire logic                               THR_LO_WR_I,
  input  wire logic [tcc_pkg::TCC_TEMP_W-1:0]     THR_DATA_I,
  input  wire logic                               INT_EN_WR_I,
  input  wire logic [1:0]                         INT_EN_DATA_I,
  output logic [tcc_pkg::TCC_TEMP_W-1:0]          ALARM_UPPER_THRESHOLD_O,
  output logic [tcc_pkg::TCC_TEMP_W-1:0]          ALARM_LOWER_THRESHOLD_O,
  output logic [1:0]                              INT_EN_O,
  // alarm status, cleared by a status read
  input  wire logic                               STATUS_RD_I,
  output logic                                    TEMP_HI_O,
  output logic                                    TEMP_LO_O,
  output logic                                    ALARM_FLAG_O,
  // general pins
  input  wire logic                               GPIO_MODE_WR_I,
  input  wire logic [2*tcc_pkg::TCC_NUM_GPIO-1:0] GPIO_MODE_DATA_I,
  input  wire logic                               GPIO_OUT_WR_I,
  input  wire logic [tcc_pkg::TCC_NUM_GPIO-1:0]   GPIO_OUT_DATA_I,
  input  wire logic [tcc_pkg::TCC_NUM_GPIO-1:0]   GPIO_I,
  output logic [tcc_pkg::TCC_NUM_GPIO-1:0]        GPIO_O,
  output logic [tcc_pkg::TCC_NUM_GPIO-1:0]        GPIO_OE_N_O,
  output logic [tcc_pkg::TCC_NUM_GPIO-1:0]        GPIO_PULLDOWN_O,
  output logic [2*tcc_pkg::TCC_NUM_GPIO-1:0]      GPIO_MODE_O,
  output logic [tcc_pkg::TCC_NUM_GPIO-1:0]        LOCATION_O,
  // identity
  output logic [tcc_pkg::TCC_ROM_W-1:0]           ROM_CODE_O
);

  import tcc_pkg::*;

  ////////////////////////////////////////
  // declarations

  tcc_state_type                state_r;
  tcc_state_type                state_nxt;
  logic                         adc_start_r;
  logic                         standby_r;
  logic                         busy_r;
  logic [TCC_TEMP_W-1:0]        result_r;
  logic [TCC_TEMP_W-1:0]        fifo_data_r;
  logic [$clog2(FIFO_DEPTH):0]  fifo_count_r;
  logic                         fifo_empty_r;
  logic                         fifo_ovf_r;
  logic [TCC_TEMP_W-1:0]        thr_hi_r;
  logic [TCC_TEMP_W-1:0]        thr_lo_r;
  logic [1:0]                   int_en_r;
  logic                         temp_hi_r;
  logic                         temp_lo_r;
  logic                         alarm_flag_r;
  logic [2*TCC_NUM_GPIO-1:0]    gpio_mode_r;
  logic [TCC_NUM_GPIO-1:0]      gpio_out_r;
  logic [TCC_NUM_GPIO-1:0]      gpio_oe_n_r;
  logic [TCC_NUM_GPIO-1:0]      gpio_oe_n_nxt;
  logic [TCC_NUM_GPIO-1:0]      pulldown_r;
  logic [TCC_NUM_GPIO-1:0]      pulldown_nxt;
  logic [TCC_NUM_GPIO-1:0]      location_r;
  logic [TCC_NUM_GPIO-1:0]      location_nxt;
  logic [TCC_NUM_GPIO-1:0]      pin_level;
  logic                         conv_pin_prev_r;
  logic                         dq_oe_n_r;
  logic [TCC_ROM_W-1:0]         rom_r;

  tcc_res_if #(.W(TCC_TEMP_W), .DEPTH(FIFO_DEPTH)) res ();

  ////////////////////////////////////////
  // submodules

  tcc_fifo #(
    .W     (TCC_TEMP_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i  (CLK_SYS_I),
    .srst_i (SRST_I),
    .res    (res.store)
  );

  tcc_pin_sync #(
    .N (TCC_NUM_GPIO)
  ) u_pin_sync (
    .clk_i   (CLK_SYS_I),
    .srst_i  (SRST_I),
    .pin_i   (GPIO_I),
    .level_o (pin_level)
  );

  ////////////////////////////////////////
  // conversion requests

  wire [1:0] mode_int  = gpio_mode_r[2*TCC_PIN_INT +: 2];
  wire [1:0] mode_conv = gpio_mode_r[2*TCC_PIN_CONV +: 2];

  // R2: convert command
  wire cmd_conv = CMD_VALID_I & (CMD_CODE_I == TCC_CMD_CONVERT);

  // R3: pin rising edge
  wire pin_conv = (mode_conv == TCC_MODE_SPECIAL) & pin_level[TCC_PIN_CONV] & ~conv_pin_prev_r;

  wire start_req = cmd_conv | pin_conv;
  wire in_store  = (state_r == TCC_ST_STORE);

  ////////////////////////////////////////
  // conversion sequencer

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      // R1: standby until asked
      TCC_ST_STANDBY: begin
        if (start_req) begin
          state_nxt = TCC_ST_START;
        end
      end
      // R16: requests outside standby fall through unseen
      TCC_ST_START: begin
        state_nxt = TCC_ST_WAIT;
      end
      TCC_ST_WAIT: begin
        if (ADC_DONE_I) begin
          state_nxt = TCC_ST_STORE;
        end
      end
      // R5: store then standby
      TCC_ST_STORE: begin
        state_nxt = TCC_ST_STANDBY;
      end
      default: begin
        state_nxt = TCC_ST_STANDBY;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      state_r     <= TCC_ST_STANDBY;
      adc_start_r <= 1'b0;
      standby_r   <= 1'b1;
      busy_r      <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      adc_start_r <= (state_nxt == TCC_ST_START);
      standby_r   <= (state_nxt == TCC_ST_STANDBY);
      busy_r      <= (state_nxt != TCC_ST_STANDBY);
    end
  end

  // R7: converter word kept as signed two's complement, never rescaled
  // R8: one count is TCC_STEP_UDEGC micro-degC
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      result_r <= '0;
    end else if ((state_r == TCC_ST_WAIT) & ADC_DONE_I) begin
      result_r <= ADC_DATA_I;
    end
  end

  ////////////////////////////////////////
  // result fifo

  // R5: one word per conversion
  assign res.push      = in_store;
  assign res.push_data = result_r;
  // R6: reader pops one word per strobe
  assign res.pop       = FIFO_POP_I;

  // a full fifo keeps its oldest words; the new word is lost and flagged
  wire ovf_set = in_store & res.full;

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      fifo_data_r  <= '0;
      fifo_count_r <= '0;
      fifo_empty_r <= 1'b1;
      fifo_ovf_r   <= 1'b0;
    end else begin
      fifo_data_r  <= res.head;
      fifo_count_r <= res.count;
      fifo_empty_r <= res.empty;
      fifo_ovf_r   <= ovf_set | (fifo_ovf_r & ~STATUS_RD_I);
    end
  end

  ////////////////////////////////////////
  // thresholds and alarms

  // R10: volatile thresholds, back to defaults at reset
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      thr_hi_r <= TCC_ALARM_HI_RST;
      thr_lo_r <= TCC_ALARM_LO_RST;
      int_en_r <= TCC_INT_EN_RST;
    end else begin
      if (THR_HI_WR_I) begin
        thr_hi_r <= THR_DATA_I;
      end
      if (THR_LO_WR_I) begin
        thr_lo_r <= THR_DATA_I;
      end
      if (INT_EN_WR_I) begin
        int_en_r <= INT_EN_DATA_I;
      end
    end
  end

  // R15: signed compare after each conversion
  wire above_hi = in_store & ($signed(result_r) > $signed(thr_hi_r));
  wire below_lo = in_store & ($signed(result_r) < $signed(thr_lo_r));
  wire flag_set = (above_hi & int_en_r[TCC_INT_EN_HI_POS])
                | (below_lo & int_en_r[TCC_INT_EN_LO_POS]);

  // a new alarm in the cycle of a status read survives the read
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      temp_hi_r    <= 1'b0;
      temp_lo_r    <= 1'b0;
      alarm_flag_r <= 1'b0;
    end else begin
      temp_hi_r    <= above_hi | (temp_hi_r & ~STATUS_RD_I);
      temp_lo_r    <= below_lo | (temp_lo_r & ~STATUS_RD_I);
      alarm_flag_r <= flag_set | (alarm_flag_r & ~STATUS_RD_I);
    end
  end

  ////////////////////////////////////////
  // general pins

  // R14: mode fields, pulldown input by default
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      gpio_mode_r <= TCC_GPIO_MODE_RST;
      gpio_out_r  <= TCC_GPIO_OUT_RST;
    end else begin
      if (GPIO_MODE_WR_I) begin
        gpio_mode_r <= GPIO_MODE_DATA_I;
      end
      if (GPIO_OUT_WR_I) begin
        gpio_out_r <= GPIO_OUT_DATA_I;
      end
    end
  end

  for (genvar i = 0; i < TCC_NUM_GPIO; i++) begin : g_pin
    wire [1:0] mode   = gpio_mode_r[2*i +: 2];
    wire       is_int = (i == TCC_PIN_INT) & (mode_int == TCC_MODE_SPECIAL);
    wire       is_in  = (mode == TCC_MODE_HIZ) | (mode == TCC_MODE_PULLDN);
    // R11: interrupt pulls low while the alarm flag stands
    wire       drive  = ((mode == TCC_MODE_OD_OUT) & ~gpio_out_r[i]) | (is_int & alarm_flag_r);
    assign gpio_oe_n_nxt[i] = ~drive;
    assign pulldown_nxt[i]  = (mode == TCC_MODE_PULLDN);
    // R12: location bits from input pins
    assign location_nxt[i]  = is_in & pin_level[i];
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      gpio_oe_n_r     <= '1;
      pulldown_r      <= '1;
      location_r      <= '0;
      conv_pin_prev_r <= 1'b0;
    end else begin
      gpio_oe_n_r     <= gpio_oe_n_nxt;
      pulldown_r      <= pulldown_nxt;
      location_r      <= location_nxt;
      conv_pin_prev_r <= pin_level[TCC_PIN_CONV];
    end
  end

  ////////////////////////////////////////
  // data line and identity

  // R13: only ever pull low or release
  // R4: the line stays released while the master holds the strong pullup
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      dq_oe_n_r <= 1'b1;
    end else begin
      dq_oe_n_r <= ~(DQ_PULL_LOW_I & ~busy_r);
    end
  end

  // R9: fixed serial code
  always_ff @(posedge CLK_SYS_I) begin
    rom_r <= ROM_CODE;
  end

  ////////////////////////////////////////
  // outputs

  assign DQ_O                    = 1'b0;
  assign DQ_OE_N_O               = dq_oe_n_r;
  assign ADC_START_O             = adc_start_r;
  assign STANDBY_O               = standby_r;
  assign CONV_BUSY_O             = busy_r;
  assign LAST_RESULT_O           = result_r;
  assign FIFO_DATA_O             = fifo_data_r;
  assign FIFO_COUNT_O            = fifo_count_r;
  assign FIFO_EMPTY_O            = fifo_empty_r;
  assign FIFO_OVF_O              = fifo_ovf_r;
  assign ALARM_UPPER_THRESHOLD_O = thr_hi_r;
  assign ALARM_LOWER_THRESHOLD_O = thr_lo_r;
  assign INT_EN_O                = int_en_r;
  assign TEMP_HI_O               = temp_hi_r;
  assign TEMP_LO_O               = temp_lo_r;
  assign ALARM_FLAG_O            = alarm_flag_r;
  // open-drain pins never drive high
  assign GPIO_O                  = '0;
  assign GPIO_OE_N_O             = gpio_oe_n_r;
  assign GPIO_PULLDOWN_O         = pulldown_r;
  assign GPIO_MODE_O             = gpio_mode_r;
  assign LOCATION_O              = location_r;
  assign ROM_CODE_O              = rom_r;

endmodule : tcc_top

`default_nettype wire

/* bench/tcc_adc_model.sv */
// converter stand-in that answers each start after a chosen delay
`timescale 1ns/100ps
`default_nettype none

module tcc_adc_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  // request and answer
  input  wire logic        start_i,
  input  wire logic [7:0]  dly_i,
  input  wire logic [15:0] word_i,
  output logic             done_o,
  output logic [15:0]      data_o
);
  logic       run_r;
  logic [7:0] cnt_r;

  assign done_o = run_r && cnt_r == 8'h00;
  // data is junk without done
  assign data_o = done_o ? word_i : ~word_i ^ {cnt_r, cnt_r};

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      run_r <= 1'b0;
      cnt_r <= 8'h00;
    end else if (start_i) begin
      run_r <= 1'b1;
      cnt_r <= dly_i;
    end else if (run_r) begin
      run_r <= cnt_r != 8'h00;
      cnt_r <= cnt_r - 8'h01;
    end
  end
endmodule : tcc_adc_model

`default_nettype wire

/* bench/tcc_properties.sv */
// concurrent checks on the ports of the conversion control top
`timescale 1ns/100ps
`default_nettype none

module tcc_properties #(
  parameter  int FIFO_DEPTH = 32,
  localparam int CW         = $clog2(FIFO_DEPTH)
) (
  // clock and reset
  input wire logic        CLK_SYS_I,
  input wire logic        SRST_I,
  // requests and converter
  input wire logic        CMD_VALID_I,
  input wire logic [7:0]  CMD_CODE_I,
  input wire logic        ADC_START_O,
  input wire logic        ADC_DONE_I,
  input wire logic [15:0] ADC_DATA_I,
  // status and results
  input wire logic        STANDBY_O,
  input wire logic        CONV_BUSY_O,
  input wire logic [15:0] LAST_RESULT_O,
  input wire logic        FIFO_POP_I,
  input wire logic [CW:0] FIFO_COUNT_O,
  input wire logic        FIFO_OVF_O,
  input wire logic [15:0] ALARM_UPPER_THRESHOLD_O,
  input wire logic        TEMP_HI_O,
  input wire logic        ALARM_FLAG_O,
  // pins
  input wire logic        DQ_O,
  input wire logic        DQ_OE_N_O,
  input wire logic [5:0]  GPIO_MODE_O,
  input wire logic [2:0]  GPIO_OE_N_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SRST_I);

  logic take;
  logic fin;
  assign take = CMD_VALID_I && CMD_CODE_I == 8'h44 && STANDBY_O;
  // a done pulse only counts while busy and past the start pulse, waiting on the converter or storing
  assign fin  = ADC_DONE_I && CONV_BUSY_O && !ADC_START_O;

  property p_rst; $fell(SRST_I) |-> STANDBY_O && !CONV_BUSY_O && !ADC_START_O; endproperty
  a_rst: assert property (p_rst) else $error("not in standby after reset");
  property p_go; take |=> ADC_START_O ##1 (!ADC_START_O && CONV_BUSY_O); endproperty
  a_go: assert property (p_go) else $error("start pulse wrong");
  property p_ign; CMD_VALID_I && CONV_BUSY_O |=> !ADC_START_O; endproperty
  a_ign: assert property (p_ign) else $error("request taken while busy");
  property p_st; fin |=> LAST_RESULT_O == $past(ADC_DATA_I) ##1 STANDBY_O; endproperty
  a_st: assert property (p_st) else $error("result not stored");
  property p_cnt;
    fin && !FIFO_POP_I && FIFO_COUNT_O < FIFO_DEPTH |-> ##3 FIFO_COUNT_O == $past(FIFO_COUNT_O, 3) + 1;
  endproperty
  a_cnt: assert property (p_cnt) else $error("fifo count not advanced");
  property p_ovf; fin && FIFO_COUNT_O == FIFO_DEPTH |-> ##[1:3] FIFO_OVF_O; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not flagged");
  property p_hi;
    fin && $signed(ADC_DATA_I) > $signed(ALARM_UPPER_THRESHOLD_O) |-> ##[2:3] TEMP_HI_O;
  endproperty
  a_hi: assert property (p_hi) else $error("upper alarm missed");
  property p_int; ALARM_FLAG_O && GPIO_MODE_O[1:0] == 2'h3 |=> !GPIO_OE_N_O[0]; endproperty
  a_int: assert property (p_int) else $error("interrupt pin not low");
  property p_dq; CONV_BUSY_O ##1 CONV_BUSY_O |-> DQ_OE_N_O && !DQ_O; endproperty
  a_dq: assert property (p_dq) else $error("data line pulled in conversion");

  c_take: cover property (take);
  c_full: cover property (fin && FIFO_COUNT_O == FIFO_DEPTH);
  c_int: cover property (ALARM_FLAG_O ##1 !GPIO_OE_N_O[0]);
endmodule : tcc_properties

bind tcc_top tcc_properties #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (
  .CLK_SYS_I, .SRST_I, .CMD_VALID_I, .CMD_CODE_I, .ADC_START_O, .ADC_DONE_I, .ADC_DATA_I,
  .STANDBY_O, .CONV_BUSY_O, .LAST_RESULT_O, .FIFO_POP_I, .FIFO_COUNT_O, .FIFO_OVF_O,
  .ALARM_UPPER_THRESHOLD_O, .TEMP_HI_O, .ALARM_FLAG_O, .DQ_O, .DQ_OE_N_O, .GPIO_MODE_O,
  .GPIO_OE_N_O
);

`default_nettype wire

/* bench/temp_conversion_control_test.sv */
// self-checking bench of the conversion control top
`timescale 1ns/100ps
`default_nettype none

module temp_conversion_control_test;
  import tcc_pkg::*;
  // serial code under test; the value is arbitrary
  localparam logic [63:0] ROM_V = 64'h0fed_cba9_8765_4321;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  stb = 8'h00;
  logic [15:0] wdat = 16'h0000;
  logic        dq_pl = 1'b0;
  logic [2:0]  gpi = 3'h0;
  logic [7:0]  dly = 8'h00;
  logic [15:0] word = 16'h0000;
  logic        done, st, busy, a_st, ovf, empty, t_hi, t_lo, alarm, dq_oe_n;
  logic [15:0] last, fdata, thr_up, thr_lo, adc_d;
  logic [5:0]  fcnt, mode;
  logic [2:0]  oe_n, pd, loc;
  logic [63:0] rom;
  int          n_errors = 0;
  int          compares = 0;
  int          n_start = 0;

  tcc_top #(.ROM_CODE(ROM_V)) DUT (
    .CLK_SYS_I(clk), .SRST_I(srst), .CMD_VALID_I(stb[7]), .CMD_CODE_I(wdat[7:0]),
    .DQ_PULL_LOW_I(dq_pl), .DQ_O(), .DQ_OE_N_O(dq_oe_n), .ADC_START_O(a_st),
    .ADC_DONE_I(done), .ADC_DATA_I(adc_d), .STANDBY_O(st), .CONV_BUSY_O(busy),
    .LAST_RESULT_O(last), .FIFO_POP_I(stb[6]), .FIFO_DATA_O(fdata), .FIFO_COUNT_O(fcnt),
    .FIFO_EMPTY_O(empty), .FIFO_OVF_O(ovf), .THR_HI_WR_I(stb[0]), .THR_LO_WR_I(stb[1]),
    .THR_DATA_I(wdat), .INT_EN_WR_I(stb[2]), .INT_EN_DATA_I(wdat[1:0]),
    .ALARM_UPPER_THRESHOLD_O(thr_up), .ALARM_LOWER_THRESHOLD_O(thr_lo), .INT_EN_O(),
    .STATUS_RD_I(stb[5]), .TEMP_HI_O(t_hi), .TEMP_LO_O(t_lo), .ALARM_FLAG_O(alarm),
    .GPIO_MODE_WR_I(stb[3]), .GPIO_MODE_DATA_I(wdat[5:0]), .GPIO_OUT_WR_I(stb[4]),
    .GPIO_OUT_DATA_I(wdat[2:0]), .GPIO_I(gpi), .GPIO_O(), .GPIO_OE_N_O(oe_n),
    .GPIO_PULLDOWN_O(pd), .GPIO_MODE_O(mode), .LOCATION_O(loc), .ROM_CODE_O(rom)
  );

  tcc_adc_model u_adc (
    .clk_i(clk), .srst_i(srst), .start_i(a_st), .dly_i(dly), .word_i(word),
    .done_o(done), .data_o(adc_d)
  );

  initial begin
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (a_st === 1'b1) n_start++;
  end

  task give_verdict;
    if (n_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  task chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tk

  // one strobe pulse per call
  task wr(input int k, input logic [15:0] d);
    @(posedge clk);
    wdat <= d;
    stb <= 8'h01 << k;
    @(posedge clk);
    stb <= 8'h00;
  endtask : wr

  task wait_st(input logic v);
    int n;
    n = 0;
    while (st !== v && n < 300) begin
      tk(1);
      n++;
    end
    if (n == 300) begin
      chk("timeout", 0, 1);
      give_verdict();
    end
  endtask : wait_st

  task conv(input logic [15:0] w, input logic [7:0] d, input bit dbl);
    word <= w;
    dly <= d;
    // master leaves the line alone while converting
    dq_pl <= 1'b0;
    wr(7, 16'h0044);
    if (dbl) wr(7, 16'h0044);
    tk(1);
    wait_st(1'b1);
    tk(2);
    chk("last", last, w);
  endtask : conv

  task pop_chk(input logic [15:0] e);
    chk("head", fdata, e);
    wr(6, 16'h0000);
    tk(2);
  endtask : pop_chk

  task s_reset;
    chk("standby", st, 1);
    chk("busy", busy, 0);
    chk("empty", empty, 1);
    chk("thr_up", thr_up, 16'h7fff);
    chk("thr_lo", thr_lo, 16'h8000);
    chk("mode", mode, 6'h2a);
    chk("pulldown", pd, 3'h7);
    chk("rom", rom, ROM_V);
  endtask : s_reset

  task s_codes;
    logic [15:0] w [5] = '{16'h1ce8, 16'hffff, 16'hff38, 16'h0001, 16'h8000};
    int          u [5] = '{37000000, -5000, -1000000, 5000, -163840000};
    int          n0;
    n0 = n_start;
    for (int i = 0; i < 5; i++) begin
      conv(w[i], 8'(i * 3), i == 0);
      chk("udegc", $signed(last) * TCC_STEP_UDEGC, u[i]);
      chk("sign", last[15], u[i] < 0);
    end
    chk("starts", n_start - n0, 5);
    chk("count", fcnt, 5);
    for (int i = 0; i < 5; i++) pop_chk(w[i]);
  endtask : s_codes

  task s_bad;
    int n0;
    n0 = n_start;
    wr(7, 16'h0045);
    tk(4);
    chk("bad code", n_start - n0, 0);
  endtask : s_bad

  task s_pin;
    word <= 16'h0bb8;
    wr(3, 16'h002e);
    @(posedge clk);
    gpi <= 3'h2;
    tk(1);
    wait_st(1'b0);
    wait_st(1'b1);
    tk(2);
    chk("pin conv", last, 16'h0bb8);
    pop_chk(16'h0bb8);
    gpi <= 3'h0;
    wr(3, 16'h002a);
  endtask : s_pin

  task s_alarm;
    wr(0, 16'h1000);
    wr(1, 16'h0000);
    wr(2, 16'h0001);
    wr(3, 16'h002b);
    conv(16'h1ce8, 8'h04, 1'b0);
    chk("hi", t_hi, 1);
    chk("lo", t_lo, 0);
    chk("flag", alarm, 1);
    chk("int pin", oe_n[0], 0);
    wr(5, 16'h0000);
    tk(3);
    chk("hi clr", t_hi, 0);
    chk("int clr", oe_n[0], 1);
    conv(16'hffff, 8'h04, 1'b0);
    chk("lo", t_lo, 1);
    chk("masked", alarm, 0);
    pop_chk(16'h1ce8);
    pop_chk(16'hffff);
    wr(5, 16'h0000);
    wr(3, 16'h002a);
  endtask : s_alarm

  task s_fifo;
    for (int i = 0; i < 33; i++) conv(16'(i), 8'h00, 1'b0);
    chk("full", fcnt, 32);
    chk("ovf", ovf, 1);
    for (int i = 0; i < 32; i++) pop_chk(16'(i));
    wr(6, 16'h0000);
    tk(2);
    chk("count", fcnt, 0);
    chk("empty", empty, 1);
  endtask : s_fifo

  task s_gpio;
    wr(3, 16'h0000);
    @(posedge clk);
    gpi <= 3'h5;
    tk(8);
    chk("location", loc, 3'h5);
    chk("pulldown", pd, 3'h0);
    wr(3, 16'h0015);
    wr(4, 16'h0002);
    tk(2);
    chk("od out", oe_n, 3'h2);
    chk("location", loc, 3'h0);
    @(posedge clk);
    dq_pl <= 1'b1;
    tk(3);
    chk("dq low", dq_oe_n, 0);
  endtask : s_gpio

  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    tk(1);
    s_reset();
    s_codes();
    s_bad();
    s_pin();
    s_alarm();
    s_fifo();
    s_gpio();
    give_verdict();
  end
endmodule : temp_conversion_control_test

`default_nettype wire
